// file: vvsr_pkg.sv
// Constants shared by the video encoder subcarrier and blanking-interval bank.
package vvsr_pkg;

	// Register subaddresses on the five-bit control port.
	localparam logic [4:0] ADDR_FREQ_BYTE0 = 5'h09;
	localparam logic [4:0] ADDR_FREQ_BYTE3 = 5'h0c;
	localparam logic [4:0] ADDR_PHASE = 5'h0d;
	localparam logic [4:0] ADDR_CAP_EVEN0 = 5'h0e;
	localparam logic [4:0] ADDR_CAP_EVEN1 = 5'h0f;
	localparam logic [4:0] ADDR_CAP_ODD0 = 5'h10;
	localparam logic [4:0] ADDR_CAP_ODD1 = 5'h11;
	localparam logic [4:0] ADDR_VBI_CTRL0 = 5'h12;
	localparam logic [4:0] ADDR_VBI_CTRL3 = 5'h15;
	localparam logic [4:0] ADDR_COPY_WIDE0 = 5'h16;
	localparam logic [4:0] ADDR_COPY_WIDE2 = 5'h18;
	localparam logic [4:0] ADDR_TEXT_EDGES = 5'h19;

	// Reset values; the frequency word defaults to the NTSC increment.
	localparam logic [7:0] RST_FREQ_BYTE0 = 8'h16;
	localparam logic [7:0] RST_FREQ_BYTE1 = 8'h7c;
	localparam logic [7:0] RST_FREQ_BYTE2 = 8'hf0;
	localparam logic [7:0] RST_FREQ_BYTE3 = 8'h21;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Field positions inside the copy/wide control register.
	localparam int CW_AUTO_BIT = 4;
	localparam int CW_ODD_EN_BIT = 5;
	localparam int CW_EVEN_EN_BIT = 6;
	localparam int CW_WIDE_EN_BIT = 7;

	// Data-service line numbers.
	localparam logic [9:0] LINE_COPY_ODD = 10'h014;
	localparam logic [9:0] LINE_COPY_EVEN = 10'h11b;
	localparam logic [9:0] LINE_CAP_ODD = 10'h015;
	localparam logic [9:0] LINE_CAP_EVEN = 10'h11c;
	localparam logic [9:0] LINE_WIDE = 10'h017;
	localparam logic [9:0] VBI_FIRST_ODD = 10'h007;
	localparam logic [9:0] VBI_FIRST_EVEN = 10'h10e;
	localparam logic [9:0] VBI_LINES = 10'h010;

	// Checksum preset and feedback taps for x^6 + x + 1.
	localparam logic [5:0] CRC_PRESET = 6'h3f;
	localparam logic [5:0] CRC_TAPS = 6'h03;

	// Teletext request timing.
	localparam longint CLK_HZ = 25000000;
	localparam longint TEXT_BIT_HZ = 6937500;
	localparam longint TEXT_BITS = 360;
	localparam int TEXT_REQ_CYCLES = int'(TEXT_BITS * CLK_HZ / TEXT_BIT_HZ);
	localparam logic [11:0] TEXT_REQ_START = 12'h0c8;
	localparam logic [11:0] HCNT_MAX = 12'hfff;

	typedef enum logic [1:0] {
		VVSR_TQ_IDLE = 2'b00,
		VVSR_TQ_WAIT = 2'b01,
		VVSR_TQ_HIGH = 2'b10
	} vvsr_tq_e;

endpackage

// file: vvsr_regs.sv
// Subcarrier synthesiser, caption, blanking-line and copy/wide register bank.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Four frequency bytes form 32-bit increment
// - Phase register offsets subcarrier, 1.41 degree steps
// - Two even-field caption bytes held
// - Two odd-field caption bytes held
// - Four registers: one bit per blanking line
// - NTSC: set bit suppresses line pedestal
// - PAL: set bit enables line teletext
// - Upper nibble delays request rising edge
// - Lower nibble advances request falling edge
// - Zero fall nibble: fall tracks rise
// - Low four bits are final copy bits
// - Auto bit selects internal or stored checksum
// - Copy data per field enable, NTSC only
// - Wide signalling when enabled, PAL only
// - Shared bits follow standard: copy or wide
// - Top two bits copy only, replaced by checksum when auto set
// - Checksum x^6+x+1, preset ones, fourteen bits
// - Copy data on lines 20 and 283
// - Wide signalling on line 23
// - Captions on lines 21 and 284
module vvsr_regs
	import vvsr_pkg::*;
#(
	parameter int REQ_CYCLES = TEXT_REQ_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic pal_mode,
	input wire logic field_odd,
	input wire logic line_start,
	input wire logic [9:0] line_num,
	input wire logic text_data_input,
	output logic [7:0] reg_rdata,
	output logic [7:0] subcarrier_phase_out,
	output logic pedestal_off,
	output logic text_line_enable,
	output logic text_request_strobe,
	output logic text_data_out,
	output logic caption_active,
	output logic [15:0] caption_word,
	output logic copy_active,
	output logic [19:0] copy_word,
	output logic wide_active,
	output logic [13:0] wide_word
);

	// The window must outlast both nibble shifts and must close before the
	// saturating line counter stops.
	if (REQ_CYCLES < 32
			|| REQ_CYCLES > int'(HCNT_MAX - TEXT_REQ_START) - 15) begin
		$error("REQ_CYCLES out of range");
	end

	localparam logic [11:0] REQ_LEN = REQ_CYCLES[11:0];

	typedef struct packed {
		logic [3:0][7:0] freq;
		logic [7:0] phase;
		logic [1:0][7:0] cap_even;
		logic [1:0][7:0] cap_odd;
		logic [3:0][7:0] vbi;
		logic [2:0][7:0] cw;
		logic [7:0] tc;
		logic [31:0] acc;
		logic [7:0] sc_phase;
		logic [7:0] rdata;
		logic [11:0] hcnt;
		vvsr_tq_e tq;
		logic strobe;
		logic ped_off;
		logic text_line;
		logic cap_act;
		logic [15:0] cap_word;
		logic copy_act;
		logic [19:0] copy_word;
		logic wide_act;
		logic [13:0] wide_word;
		logic ttx_s1;
		logic ttx_s2;
		logic ttx_out;
	} vvsr_state_s;

	vvsr_state_s st_reg;
	vvsr_state_s st_next;
	logic [1:0] rst_pipe_reg;
	logic rst_sync_n;

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; assertion stays asynchronous.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Checksum over C0..C13, C0 shifted in first.
	function automatic logic [5:0] crc6(input logic [13:0] d);
		logic [5:0] c;
		logic fb;
		c = CRC_PRESET;
		fb = 1'b0;
		for (int i = 0; i < 14; i++) begin
			fb = d[i] ^ c[5];
			c = {c[4:0], 1'b0} ^ (fb ? CRC_TAPS : 6'h00);
		end
		return c;
	endfunction

	// Per-line control bit for the current line, zero outside the window.
	function automatic logic vbi_bit(input logic [3:0][7:0] v,
			input logic odd, input logic [9:0] ln);
		logic [9:0] first;
		logic [9:0] idx;
		logic [15:0] bits;
		first = odd ? VBI_FIRST_ODD : VBI_FIRST_EVEN;
		bits = odd ? {v[1], v[0]} : {v[3], v[2]};
		idx = ln - first;
		return (ln >= first && idx < VBI_LINES) ? bits[idx[3:0]] : 1'b0;
	endfunction

	function automatic logic [7:0] reg_read(input vvsr_state_s s,
			input logic [4:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a >= ADDR_FREQ_BYTE0 && a <= ADDR_FREQ_BYTE3) begin
			r = s.freq[2'(a - ADDR_FREQ_BYTE0)];
		end else if (a >= ADDR_VBI_CTRL0 && a <= ADDR_VBI_CTRL3) begin
			r = s.vbi[2'(a - ADDR_VBI_CTRL0)];
		end else if (a >= ADDR_COPY_WIDE0 && a <= ADDR_COPY_WIDE2) begin
			r = s.cw[2'(a - ADDR_COPY_WIDE0)];
		end else begin
			unique case (a)
				ADDR_PHASE: r = s.phase;
				ADDR_CAP_EVEN0: r = s.cap_even[0];
				ADDR_CAP_EVEN1: r = s.cap_even[1];
				ADDR_CAP_ODD0: r = s.cap_odd[0];
				ADDR_CAP_ODD1: r = s.cap_odd[1];
				ADDR_TEXT_EDGES: r = s.tc;
				default: r = 8'h00;
			endcase
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [31:0] freq_word;
	logic [13:0] copy_data;
	logic [5:0] copy_crc;
	logic [3:0] rise_nib;
	logic [3:0] fall_nib;
	logic [11:0] rise_at;
	logic [11:0] fall_at;
	logic line_text;

	always_comb begin
		st_next = st_reg;
		freq_word = st_reg.freq;
		rise_nib = st_reg.tc[7:4];
		fall_nib = st_reg.tc[3:0];
		copy_data = {st_reg.cw[1][5:0], st_reg.cw[2]};
		copy_crc = crc6(copy_data);
		line_text = pal_mode && vbi_bit(st_reg.vbi, field_odd, line_num);
		rise_at = TEXT_REQ_START + {8'h00, rise_nib};
		// A zero fall nibble keeps the window length under rise shifts.
		if (fall_nib == 4'h0) begin
			fall_at = rise_at + REQ_LEN;
		end else begin
			fall_at = TEXT_REQ_START + REQ_LEN - {8'h00, fall_nib};
		end

		// Register writes land at the documented subaddresses.
		if (reg_wr) begin
			if (reg_addr >= ADDR_FREQ_BYTE0 && reg_addr <= ADDR_FREQ_BYTE3) begin
				st_next.freq[2'(reg_addr - ADDR_FREQ_BYTE0)] = reg_wdata;
			end else if (reg_addr >= ADDR_VBI_CTRL0
					&& reg_addr <= ADDR_VBI_CTRL3) begin
				st_next.vbi[2'(reg_addr - ADDR_VBI_CTRL0)] = reg_wdata;
			end else if (reg_addr >= ADDR_COPY_WIDE0
					&& reg_addr <= ADDR_COPY_WIDE2) begin
				st_next.cw[2'(reg_addr - ADDR_COPY_WIDE0)] = reg_wdata;
			end else begin
				unique case (reg_addr)
					ADDR_PHASE: st_next.phase = reg_wdata;
					ADDR_CAP_EVEN0: st_next.cap_even[0] = reg_wdata;
					ADDR_CAP_EVEN1: st_next.cap_even[1] = reg_wdata;
					ADDR_CAP_ODD0: st_next.cap_odd[0] = reg_wdata;
					ADDR_CAP_ODD1: st_next.cap_odd[1] = reg_wdata;
					ADDR_TEXT_EDGES: st_next.tc = reg_wdata;
					default: st_next.tc = st_reg.tc;
				endcase
			end
		end
		if (reg_rd) begin
			st_next.rdata = reg_read(st_reg, reg_addr);
		end

		// Free-running synthesiser; the phase offset rides on the top byte.
		st_next.acc = st_reg.acc + freq_word;
		st_next.sc_phase = st_reg.acc[31:24] + st_reg.phase;

		// Line services, recomputed every clock from the line position.
		st_next.ped_off = !pal_mode
			&& vbi_bit(st_reg.vbi, field_odd, line_num);
		st_next.text_line = line_text;
		st_next.cap_act = (field_odd && line_num == LINE_CAP_ODD)
			|| (!field_odd && line_num == LINE_CAP_EVEN);
		st_next.cap_word = field_odd ? {st_reg.cap_odd[1], st_reg.cap_odd[0]}
			: {st_reg.cap_even[1], st_reg.cap_even[0]};
		st_next.copy_act = !pal_mode && ((field_odd
			&& line_num == LINE_COPY_ODD && st_reg.cw[0][CW_ODD_EN_BIT])
			|| (!field_odd && line_num == LINE_COPY_EVEN
			&& st_reg.cw[0][CW_EVEN_EN_BIT]));
		// C0..C13 shared, C14..C15 copy only, C16..C19 final bits.
		st_next.copy_word = {st_reg.cw[0][3:0], st_reg.cw[1][7:6],
			copy_data};
		if (st_reg.cw[0][CW_AUTO_BIT]) begin
			st_next.copy_word[19:14] = copy_crc;
		end
		st_next.wide_act = pal_mode && line_num == LINE_WIDE
			&& st_reg.cw[0][CW_WIDE_EN_BIT];
		st_next.wide_word = copy_data;

		// Position within the line; saturates rather than wraps.
		if (line_start) begin
			st_next.hcnt = 12'h000;
		end else if (st_reg.hcnt != HCNT_MAX) begin
			st_next.hcnt = st_reg.hcnt + 12'h001;
		end

		// Request strobe only on teletext lines.
		unique case (st_reg.tq)
			VVSR_TQ_IDLE: begin
				st_next.strobe = 1'b0;
				if (line_start && line_text) begin
					st_next.tq = VVSR_TQ_WAIT;
				end
			end
			VVSR_TQ_WAIT: begin
				if (line_start) begin
					st_next.tq = VVSR_TQ_IDLE;
				end else if (st_reg.hcnt == rise_at) begin
					st_next.strobe = 1'b1;
					st_next.tq = VVSR_TQ_HIGH;
				end
			end
			VVSR_TQ_HIGH: begin
				if (line_start || st_reg.hcnt == fall_at) begin
					st_next.strobe = 1'b0;
					st_next.tq = VVSR_TQ_IDLE;
				end
			end
			default: begin
				st_next.strobe = 1'b0;
				st_next.tq = VVSR_TQ_IDLE;
			end
		endcase

		// Teletext pin is asynchronous: two flops before use.
		st_next.ttx_s1 = text_data_input;
		st_next.ttx_s2 = st_reg.ttx_s1;
		st_next.ttx_out = st_reg.ttx_s2 && st_reg.text_line;
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_reg <= '0;
			st_reg.freq <= {RST_FREQ_BYTE3, RST_FREQ_BYTE2, RST_FREQ_BYTE1,
				RST_FREQ_BYTE0};
			st_reg.phase <= RST_BYTE;
			st_reg.tq <= VVSR_TQ_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign subcarrier_phase_out = st_reg.sc_phase;
	assign pedestal_off = st_reg.ped_off;
	assign text_line_enable = st_reg.text_line;
	assign text_request_strobe = st_reg.strobe;
	assign text_data_out = st_reg.ttx_out;
	assign caption_active = st_reg.cap_act;
	assign caption_word = st_reg.cap_word;
	assign copy_active = st_reg.copy_act;
	assign copy_word = st_reg.copy_word;
	assign wide_active = st_reg.wide_act;
	assign wide_word = st_reg.wide_word;

	////////////////////////////////////////////////////////////////////////
	// Checks on driven state.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_sync_n);

	// The first edge after reset has no registered history to compare with.
	a_acc_step: assert property (
		$past(rst_sync_n)
			|-> st_reg.acc == $past(st_reg.acc) + $past(freq_word))
		else $error("accumulator did not add the increment");
	a_phase_offset: assert property (
		$past(rst_sync_n) |-> st_reg.sc_phase
			== $past(st_reg.acc[31:24]) + $past(st_reg.phase))
		else $error("phase output not offset by phase register");
	a_ped_ntsc: assert property (
		pedestal_off |-> $past(!pal_mode))
		else $error("pedestal suppressed outside NTSC");
	a_text_pal: assert property (
		text_line_enable |-> $past(pal_mode))
		else $error("teletext line enabled outside PAL");
	a_copy_lines: assert property (
		copy_active |-> $past(line_num) == LINE_COPY_ODD
			|| $past(line_num) == LINE_COPY_EVEN)
		else $error("copy data on wrong line");
	a_wide_only: assert property (
		wide_active |-> $past(pal_mode && line_num == LINE_WIDE))
		else $error("wide signalling outside PAL line");
	a_crc_auto: assert property (
		copy_active && $past(st_reg.cw[0][CW_AUTO_BIT])
			|-> copy_word[19:14] == crc6(copy_word[13:0]))
		else $error("automatic checksum wrong");
	a_copy_final: assert property (
		copy_active && !$past(st_reg.cw[0][CW_AUTO_BIT])
			|-> copy_word[19:16] == $past(st_reg.cw[0][3:0]))
		else $error("final copy bits not from register");
	a_strobe_rise: assert property (
		$rose(text_request_strobe) |-> $past(st_reg.hcnt)
			== TEXT_REQ_START + {8'h00, $past(st_reg.tc[7:4])})
		else $error("request rose at wrong position");
	a_cap_lines: assert property (
		caption_active |-> $past(line_num) == LINE_CAP_ODD
			|| $past(line_num) == LINE_CAP_EVEN)
		else $error("caption on wrong line");
	a_fall_fixed: assert property (
		$fell(text_request_strobe) && !$past(line_start)
			&& $past(st_reg.tc[3:0]) != 4'h0
			|-> $past(st_reg.hcnt) == TEXT_REQ_START + REQ_LEN
			- {8'h00, $past(st_reg.tc[3:0])})
		else $error("request fell at wrong position");
	a_fall_track: assert property (
		$fell(text_request_strobe) && !$past(line_start)
			&& $past(st_reg.tc[3:0]) == 4'h0
			|-> $past(st_reg.hcnt) == TEXT_REQ_START + REQ_LEN
			+ {8'h00, $past(st_reg.tc[7:4])})
		else $error("request window length not kept");
	a_cap_odd: assert property (
		caption_active && $past(field_odd)
			|-> caption_word == $past(st_reg.cap_odd))
		else $error("odd caption word wrong");
	a_cap_even: assert property (
		caption_active && !$past(field_odd)
			|-> caption_word == $past(st_reg.cap_even))
		else $error("even caption word wrong");
	a_wide_word: assert property (
		wide_active |-> wide_word
			== {$past(st_reg.cw[1][5:0]), $past(st_reg.cw[2])})
		else $error("wide data not from shared bits");
	a_copy_high: assert property (
		copy_active && !$past(st_reg.cw[0][CW_AUTO_BIT])
			|-> copy_word[15:14] == $past(st_reg.cw[1][7:6]))
		else $error("copy-only bits wrong");

	c_strobe: cover property ($fell(text_request_strobe));
	c_copy_auto: cover property (copy_active && st_reg.cw[0][CW_AUTO_BIT]);
	c_wide: cover property (wide_active);
	c_track: cover property ($rose(text_request_strobe)
		&& st_reg.tc[3:0] == 4'h0);

endmodule

// file: vvsr_text_src.sv
// Teletext source model that answers the request strobe with data bits.
`timescale 1ns/1ps
module vvsr_text_src (
	input wire logic mclk,
	input wire logic text_request_strobe,
	output logic text_data_input
);
	logic [6:0] pat_reg = 7'h5b;
	logic last_reg = 1'b0;

	always_ff @(posedge mclk) begin
		pat_reg <= {pat_reg[5:0], pat_reg[6] ^ pat_reg[5]};
		if (text_request_strobe) begin
			last_reg <= pat_reg[0];
		end
	end
	// Outside a request the source is idle; showing the inverse of the last
	// bit keeps a stale value from passing as good data.
	assign text_data_input = text_request_strobe ? last_reg : ~last_reg;
endmodule

// file: vvsr_regs_tb.sv
// Self-checking bench for the subcarrier and blanking-line register bank.
`timescale 1ns/1ps
module vvsr_regs_tb
	import vvsr_pkg::*;
;
	localparam int REQ = 40;
	logic mclk, rst_n, reg_wr, reg_rd, pal_mode, field_odd, line_start;
	logic text_data_input, pedestal_off, text_line_enable, text_data_out;
	logic text_request_strobe, caption_active, copy_active, wide_active;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, subcarrier_phase_out, p;
	logic [9:0] line_num;
	logic [15:0] caption_word;
	logic [19:0] copy_word;
	logic [13:0] wide_word;
	logic [2:0] tdi_hist;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int n, w;
	logic [7:0] tcs [5] = '{8'h30, 8'h32, 8'h00, 8'h70, 8'hff};
	// Each row: mode, field, line, then caption/copy/wide/pedestal/text.
	bit [16:0] rows [12] = '{
		{2'b01, 10'd20, 5'b01000}, {2'b00, 10'd283, 5'b01000},
		{2'b11, 10'd20, 5'b00000}, {2'b11, 10'd23, 5'b00100},
		{2'b01, 10'd23, 5'b00000}, {2'b01, 10'd21, 5'b10000},
		{2'b00, 10'd284, 5'b10000}, {2'b01, 10'd7, 5'b00010},
		{2'b11, 10'd7, 5'b00001}, {2'b10, 10'd285, 5'b00001},
		{2'b00, 10'd285, 5'b00010}, {2'b01, 10'd8, 5'b00000}};

	vvsr_regs #(.REQ_CYCLES(REQ)) DUT (.mclk(mclk), .rst_n(rst_n),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .pal_mode(pal_mode), .field_odd(field_odd),
		.line_start(line_start), .line_num(line_num),
		.text_data_input(text_data_input), .reg_rdata(reg_rdata),
		.subcarrier_phase_out(subcarrier_phase_out),
		.pedestal_off(pedestal_off), .text_line_enable(text_line_enable),
		.text_request_strobe(text_request_strobe),
		.text_data_out(text_data_out), .caption_active(caption_active),
		.caption_word(caption_word), .copy_active(copy_active),
		.copy_word(copy_word), .wide_active(wide_active),
		.wide_word(wide_word));
	vvsr_text_src SRC (.mclk(mclk), .text_request_strobe(text_request_strobe),
		.text_data_input(text_data_input));

////////////////////////////////////////
	task automatic chk(input logic [19:0] s, input logic [19:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic ln(input logic pm, input logic fo, input logic [9:0] l);
		@(posedge mclk);
		pal_mode <= pm;
		field_odd <= fo;
		line_num <= l;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	function automatic logic [5:0] crc6(input logic [13:0] d);
		logic [5:0] c;
		logic fb;
		c = 6'h3f;
		for (int i = 0; i < 14; i++) begin
			fb = d[i] ^ c[5];
			c = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
		end
		return c;
	endfunction
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		tdi_hist <= {tdi_hist[1:0], text_data_input};
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		pal_mode = 1'b0;
		field_odd = 1'b0;
		line_start = 1'b0;
		line_num = 10'h000;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(ADDR_FREQ_BYTE0, RST_FREQ_BYTE0);
		rd(5'h0a, RST_FREQ_BYTE1);
		rd(5'h0b, RST_FREQ_BYTE2);
		rd(ADDR_FREQ_BYTE3, RST_FREQ_BYTE3);
		for (int a = 13; a < 26; a++) begin
			rd(5'(a), RST_BYTE);
		end
		for (int a = 9; a < 26; a++) begin
			wr(5'(a), 8'(a * 37));
			rd(5'(a), 8'(a * 37));
		end
		wr(5'h1a, 8'hff);
		rd(5'h1a, 8'h00);
		rd(5'h08, 8'h00);
		// The host loads the NTSC word lowest byte first.
		wr(ADDR_FREQ_BYTE0, 8'h1f);
		wr(5'h0a, 8'h7c);
		wr(5'h0b, 8'hf0);
		wr(ADDR_FREQ_BYTE3, 8'h21);
		rd(ADDR_FREQ_BYTE0, 8'h1f);
		wr(ADDR_CAP_ODD0, 8'h34);
		wr(ADDR_CAP_ODD1, 8'h12);
		wr(ADDR_CAP_EVEN0, 8'h78);
		wr(ADDR_CAP_EVEN1, 8'h56);
		wr(ADDR_VBI_CTRL0, 8'h01);
		wr(5'h13, 8'h00);
		wr(ADDR_VBI_CTRL3, 8'h80);
		wr(ADDR_COPY_WIDE0, 8'he5);
		wr(5'h17, 8'hc9);
		wr(ADDR_COPY_WIDE2, 8'h3a);
		foreach (rows[i]) begin
			ln(rows[i][16], rows[i][15], rows[i][14:5]);
			chk({caption_active, copy_active, wide_active, pedestal_off,
				text_line_enable}, 20'(rows[i][4:0]));
		end
		ln(1'b0, 1'b1, LINE_COPY_ODD);
		chk(copy_word, 20'h5c93a);
		ln(1'b0, 1'b1, LINE_CAP_ODD);
		chk(caption_word, 16'h1234);
		ln(1'b0, 1'b0, LINE_CAP_EVEN);
		chk(caption_word, 16'h5678);
		ln(1'b1, 1'b1, LINE_WIDE);
		chk(wide_word, 14'h093a);
		wr(ADDR_COPY_WIDE0, 8'hb5);
		ln(1'b0, 1'b1, LINE_COPY_ODD);
		chk(copy_word, {crc6(14'h093a), 14'h093a});
		ln(1'b0, 1'b0, LINE_COPY_EVEN);
		chk(copy_active, 1'b0);
		// A one-step increment in the top byte makes the accumulator visible.
		wr(ADDR_FREQ_BYTE0, 8'h00);
		wr(5'h0a, 8'h00);
		wr(5'h0b, 8'h00);
		wr(ADDR_FREQ_BYTE3, 8'h01);
		repeat (2) @(posedge mclk);
		#1;
		p = subcarrier_phase_out;
		@(posedge mclk);
		#1;
		chk(subcarrier_phase_out, 8'(p + 8'h01));
		wr(ADDR_FREQ_BYTE3, 8'h00);
		wr(ADDR_PHASE, 8'h00);
		repeat (2) @(posedge mclk);
		#1;
		p = subcarrier_phase_out;
		wr(ADDR_PHASE, 8'h40);
		repeat (2) @(posedge mclk);
		#1;
		chk(subcarrier_phase_out, 8'(p + 8'h40));
		ln(1'b1, 1'b1, VBI_FIRST_ODD);
		foreach (tcs[i]) begin
			wr(ADDR_TEXT_EDGES, tcs[i]);
			@(posedge mclk);
			line_start <= 1'b1;
			@(posedge mclk);
			line_start <= 1'b0;
			n = 1;
			while (text_request_strobe !== 1'b1 && n < 400) begin
				@(posedge mclk);
				#1;
				n++;
			end
			chk(20'(n), 20'(202 + tcs[i][7:4]));
			w = 0;
			while (text_request_strobe === 1'b1 && w < 400) begin
				chk(text_data_out, tdi_hist[2]);
				@(posedge mclk);
				#1;
				w++;
			end
			chk(20'(w), (tcs[i][3:0] == 4'h0) ? 20'(REQ) :
				20'(REQ - tcs[i][3:0] - tcs[i][7:4]));
		end
		ln(1'b0, 1'b1, VBI_FIRST_ODD);
		chk(text_data_out, 1'b0);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(ADDR_PHASE, RST_BYTE);
		rd(ADDR_FREQ_BYTE0, RST_FREQ_BYTE0);
		wrap_up();
	end
endmodule
